/* File: src/cmfd_pkg.sv */
// cmfd_pkg: offsets, field positions, codes for chip mode and overrange control
// assumes an external serial control port delivers byte-wide register accesses
package cmfd_pkg;
   localparam logic [11:0] CMFD_ADDR_MODE   = 12'h200;
   localparam logic [11:0] CMFD_ADDR_DECIM  = 12'h201;
   localparam logic [11:0] CMFD_ADDR_OVR    = 12'h245;
   // writable bit masks; everything else reads zero
   localparam logic [7:0]  CMFD_MODE_WMASK  = 8'hEF;
   localparam logic [7:0]  CMFD_DECIM_WMASK = 8'h0F;
   localparam logic [7:0]  CMFD_OVR_WMASK   = 8'h0D;
   localparam logic [7:0]  CMFD_RST_VAL     = 8'h00;
   localparam int          CMFD_Q_IGN_BIT   = 5;
   localparam int          CMFD_FORCE_BIT   = 3;
   localparam int          CMFD_FVAL_BIT    = 2;
   localparam int          CMFD_FDEN_BIT    = 0;
   localparam logic [3:0]  CMFD_APP_FULL    = 4'h0;
   localparam logic [3:0]  CMFD_APP_ONE     = 4'h1;
   localparam logic [3:0]  CMFD_APP_TWO     = 4'h2;
   localparam logic [3:0]  CMFD_APP_FOUR    = 4'h3;
endpackage

/* File: src/cmfd_ctrl.sv */
// cmfd_ctrl: chip mode, decimation select and overrange pin force registers
// assumes byte writes/reads from the serial control port, synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module cmfd_ctrl
   import cmfd_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        clk_en_i,
   input  wire logic        reg_wr_i,
   input  wire logic [11:0] reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   output logic      [7:0]  reg_rdata_o,
   input  wire logic [1:0]  detect_level_i,
   output logic      [1:0]  overrange_flag_pin_o,
   output logic             overrange_detect_en_o,
   output logic             q_path_en_o,
   output logic             full_bw_mode_o,
   output logic      [3:0]  downconverter_en_o,
   output logic             decim_bypass_o,
   output logic      [5:0]  decim_ratio_o
);
   ////////////////////////////////////////////////////////////////////////
   logic [7:0] mode_r;
   logic [7:0] decim_r;
   logic [7:0] ovr_r;
   logic [1:0] pin_r;
   logic [5:0] ratio_nxt;
   wire        wr_mode  = reg_wr_i && (reg_addr_i == CMFD_ADDR_MODE);
   wire        wr_decim = reg_wr_i && (reg_addr_i == CMFD_ADDR_DECIM);
   wire        wr_ovr   = reg_wr_i && (reg_addr_i == CMFD_ADDR_OVR);
   wire        force_on = ovr_r[CMFD_FORCE_BIT];
   wire [3:0]  app      = mode_r[3:0];

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         mode_r  <= CMFD_RST_VAL;
         decim_r <= CMFD_RST_VAL;
         ovr_r   <= CMFD_RST_VAL;
      end
      else if (clk_en_i)
      begin
         // masking keeps reserved bits at zero
         if (wr_mode)
            mode_r <= reg_wdata_i & CMFD_MODE_WMASK;
         if (wr_decim)
            decim_r <= reg_wdata_i & CMFD_DECIM_WMASK;
         if (wr_ovr)
            ovr_r <= reg_wdata_i & CMFD_OVR_WMASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // unmapped addresses read zero
   assign reg_rdata_o = (reg_addr_i == CMFD_ADDR_MODE)  ? mode_r  :
                        (reg_addr_i == CMFD_ADDR_DECIM) ? decim_r :
                        (reg_addr_i == CMFD_ADDR_OVR)   ? ovr_r   :
                        8'h00;

   assign q_path_en_o    = ~mode_r[CMFD_Q_IGN_BIT];
   assign full_bw_mode_o = (app == CMFD_APP_FULL);
   // undefined app codes enable nothing rather than guess
   assign downconverter_en_o = (app == CMFD_APP_ONE)  ? 4'h1 :
                               (app == CMFD_APP_TWO)  ? 4'h3 :
                               (app == CMFD_APP_FOUR) ? 4'hF :
                               4'h0;
   assign overrange_detect_en_o = ovr_r[CMFD_FDEN_BIT];

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      case (decim_r[3:0])
         4'h0:    ratio_nxt = 6'h01;
         4'h1:    ratio_nxt = 6'h02;
         4'h2:    ratio_nxt = 6'h04;
         4'h3:    ratio_nxt = 6'h08;
         4'h4:    ratio_nxt = 6'h10;
         4'h5:    ratio_nxt = 6'h05;
         4'h6:    ratio_nxt = 6'h0A;
         4'h7:    ratio_nxt = 6'h0F;
         4'h8:    ratio_nxt = 6'h03;
         4'h9:    ratio_nxt = 6'h06;
         4'hA:    ratio_nxt = 6'h0C;
         4'hB:    ratio_nxt = 6'h18;
         4'hC:    ratio_nxt = 6'h30;
         4'hD:    ratio_nxt = 6'h14;
         4'hE:    ratio_nxt = 6'h1E;
         default: ratio_nxt = 6'h28;
      endcase
   end
   assign decim_ratio_o  = ratio_nxt;
   assign decim_bypass_o = (decim_r[3:0] == 4'h0);

   ////////////////////////////////////////////////////////////////////////
   // pin is registered: one cycle lag from detector, glitch-free output
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++)
      begin : g_pin
         always_ff @(posedge core_clk_i or negedge reset_n_i)
         begin
            if (!reset_n_i)
               pin_r[ch] <= 1'b0;
            else if (clk_en_i)
               pin_r[ch] <= force_on ? ovr_r[CMFD_FVAL_BIT]
                                     : detect_level_i[ch];
         end
      end
   endgenerate
   assign overrange_flag_pin_o = pin_r;

   ////////////////////////////////////////////////////////////////////////
   a_q_ignore: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      q_path_en_o == !mode_r[CMFD_Q_IGN_BIT])
      else $error("q path enable wrong");
   a_app_map: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (app == CMFD_APP_TWO) |-> downconverter_en_o == 4'h3)
      else $error("two downconverter mode wrong");
   a_full_bw: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      $rose(reset_n_i) |-> full_bw_mode_o)
      else $error("not full bandwidth after reset");
   a_decim_map: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (decim_r[3:0] == 4'hC) |-> decim_ratio_o == 6'h30)
      else $error("decimation 48 wrong");
   sequence s_forced;
      clk_en_i && force_on;
   endsequence
   a_force_pin: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      s_forced |=> overrange_flag_pin_o == {2{$past(ovr_r[CMFD_FVAL_BIT])}})
      else $error("forced pin level wrong");
   a_normal_pin: assert property (@(posedge core_clk_i)
      disable iff (!reset_n_i)
      (clk_en_i && !force_on) |=> overrange_flag_pin_o == $past(detect_level_i))
      else $error("normal pin path wrong");

   a_pin_ch0: assert property (@(posedge core_clk_i)
      disable iff (!reset_n_i)
      s_forced |=> overrange_flag_pin_o[0] == $past(ovr_r[CMFD_FVAL_BIT]))
      else $error("forced level on channel zero wrong");

   ////////////////////////////////////////////////////////////////////////
   // write paths: a taken write lands masked on the next edge
   sequence s_mode_wr;
      clk_en_i && wr_mode;
   endsequence

   sequence s_decim_wr;
      clk_en_i && wr_decim;
   endsequence

   sequence s_ovr_wr;
      clk_en_i && wr_ovr;
   endsequence

   a_q_write: assert property (@(posedge core_clk_i)
      disable iff (!reset_n_i)
      s_mode_wr |=> q_path_en_o == !$past(reg_wdata_i[CMFD_Q_IGN_BIT]))
      else $error("q path enable not following write");

   a_mode_write: assert property (@(posedge core_clk_i)
      disable iff (!reset_n_i)
      s_mode_wr |=> mode_r == ($past(reg_wdata_i) & CMFD_MODE_WMASK))
      else $error("mode write not masked");

   a_decim_write: assert property (@(posedge core_clk_i)
      disable iff (!reset_n_i)
      s_decim_wr |=> decim_r == ($past(reg_wdata_i) & CMFD_DECIM_WMASK))
      else $error("decimation write not masked");

   a_ovr_write: assert property (@(posedge core_clk_i)
      disable iff (!reset_n_i)
      s_ovr_wr |=> ovr_r == ($past(reg_wdata_i) & CMFD_OVR_WMASK))
      else $error("overrange write not masked");

   ////////////////////////////////////////////////////////////////////////
   // decode checks, one per documented code worth pinning down
   a_app_one: assert property (@(posedge core_clk_i)
      disable iff (!reset_n_i)
      (app == CMFD_APP_ONE) |-> downconverter_en_o == 4'h1)
      else $error("one downconverter mode wrong");

   a_app_four: assert property (@(posedge core_clk_i)
      disable iff (!reset_n_i)
      (app == CMFD_APP_FOUR) |-> downconverter_en_o == 4'hF)
      else $error("four downconverter mode wrong");

   a_app_undef: assert property (@(posedge core_clk_i)
      disable iff (!reset_n_i)
      (app > CMFD_APP_FOUR) |-> downconverter_en_o == 4'h0)
      else $error("undefined mode enabled a downconverter");

   a_full_none: assert property (@(posedge core_clk_i)
      disable iff (!reset_n_i)
      full_bw_mode_o |-> downconverter_en_o == 4'h0)
      else $error("full bandwidth with downconverter on");

   a_decim_byp: assert property (@(posedge core_clk_i)
      disable iff (!reset_n_i)
      decim_bypass_o == (decim_ratio_o == 6'h01))
      else $error("bypass and unity ratio disagree");

   a_decim_two: assert property (@(posedge core_clk_i)
      disable iff (!reset_n_i)
      (decim_r[3:0] == 4'h1) |-> decim_ratio_o == 6'h02)
      else $error("decimation 2 wrong");

   a_decim_three: assert property (@(posedge core_clk_i)
      disable iff (!reset_n_i)
      (decim_r[3:0] == 4'h8) |-> decim_ratio_o == 6'h03)
      else $error("decimation 3 wrong");

   ////////////////////////////////////////////////////////////////////////
   // read side and clock enable
   a_rd_unmapped: assert property (@(posedge core_clk_i)
      disable iff (!reset_n_i)
      ((reg_addr_i != CMFD_ADDR_MODE) && (reg_addr_i != CMFD_ADDR_DECIM) &&
       (reg_addr_i != CMFD_ADDR_OVR)) |-> reg_rdata_o == 8'h00)
      else $error("unmapped address read nonzero");

   a_rd_ovr: assert property (@(posedge core_clk_i)
      disable iff (!reset_n_i)
      (reg_addr_i == CMFD_ADDR_OVR) |-> reg_rdata_o[7:4] == 4'h0)
      else $error("overrange reserved bits read nonzero");

   // a frozen core must not even move the pins
   a_freeze: assert property (@(posedge core_clk_i)
      disable iff (!reset_n_i)
      !clk_en_i |=> ($stable(mode_r) && $stable(decim_r) &&
                     $stable(ovr_r) && $stable(pin_r)))
      else $error("state moved with clock enable low");
   a_reserved: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      ((mode_r[4] | |decim_r[7:4] | ovr_r[1] | |ovr_r[7:4]) == 1'b0))
      else $error("reserved bit set");
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// tb: directed bench for the chip mode / overrange control bank
// assumes cmfd_pkg and cmfd_ctrl are compiled before this file
`timescale 1ns/1ps
`default_nettype none
module tb;
   import cmfd_pkg::*;
   logic        core_clk_i = 1'b0;
   logic        reset_n_i  = 1'b0;
   logic        clk_en_i   = 1'b1;
   logic        reg_wr_i   = 1'b0;
   logic [11:0] reg_addr_i = 12'h000;
   logic [7:0]  reg_wdata_i = 8'h00;
   logic [1:0]  det_i = 2'h0;
   logic [7:0]  rd;
   logic [1:0]  pin;
   logic        den, qen, fbw, byp;
   logic [3:0]  dce;
   logic [5:0]  ratio;
   int          fails = 0, checked = 0, cyc = 0;
   logic [5:0]  rt [16] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h05, 6'h0A,
      6'h0F, 6'h03, 6'h06, 6'h0C, 6'h18, 6'h30, 6'h14, 6'h1E, 6'h28};
   logic [3:0]  dt [4] = '{4'h0, 4'h1, 4'h3, 4'hF};
   cmfd_ctrl i_cmfd_ctrl (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
      .clk_en_i(clk_en_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(rd), .detect_level_i(det_i),
      .overrange_flag_pin_o(pin), .overrange_detect_en_o(den),
      .q_path_en_o(qen), .full_bw_mode_o(fbw), .downconverter_en_o(dce),
      .decim_bypass_o(byp), .decim_ratio_o(ratio));
////////////////////////////////////////////////////////////////////////////////
   initial forever #10 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         fails++;
         finish_test();
      end
   end
   task automatic finish_test();
      if (fails == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string msg);
      checked++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   // strobe held across exactly one rising edge
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge core_clk_i);
      reg_wr_i = 1'b1; reg_addr_i = a; reg_wdata_i = d;
      @(negedge core_clk_i);
      reg_wr_i = 1'b0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [7:0] e);
      reg_addr_i = a;
      #1 chk(rd, e, "readback");
   endtask
////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rdc(CMFD_ADDR_MODE, 8'h00);
      rdc(CMFD_ADDR_DECIM, 8'h00);
      chk({qen, fbw, byp, pin, 3'h0}, 8'hE0, "reset outs");
      chk({dce, 4'h0}, 8'h00, "reset dc");
   endtask
   task automatic t_mode();
      for (int i = 0; i < 4; i++)
      begin
         wr(CMFD_ADDR_MODE, 8'h30 | 8'(i));
         chk({qen, fbw, dce, 2'h0}, {1'b0, i == 0, dt[i], 2'h0}, "mode");
         wr(CMFD_ADDR_MODE, 8'(i));
         chk({7'h0, qen}, 8'h01, "q kept");
      end
      wr(CMFD_ADDR_MODE, 8'hFF);
      chk({dce, 4'h0}, 8'h00, "undef app");
      rdc(CMFD_ADDR_MODE, 8'hEF);
   endtask
   task automatic t_decim();
      for (int i = 0; i < 16; i++)
      begin
         wr(CMFD_ADDR_DECIM, 8'hF0 | 8'(i));
         chk({byp, 1'b0, ratio}, {i == 0, 1'b0, rt[i]}, "ratio");
         rdc(CMFD_ADDR_DECIM, 8'(i));
      end
   endtask
   task automatic t_force();
      det_i = 2'h2;
      wr(CMFD_ADDR_OVR, 8'h00);
      @(negedge core_clk_i) chk({6'h0, pin}, 8'h02, "normal pin");
      wr(CMFD_ADDR_OVR, 8'h0C);
      @(negedge core_clk_i) chk({6'h0, pin}, 8'h03, "forced hi");
      wr(CMFD_ADDR_OVR, 8'h08);
      @(negedge core_clk_i) chk({6'h0, pin}, 8'h00, "forced lo");
      wr(CMFD_ADDR_OVR, 8'hFF);
      rdc(CMFD_ADDR_OVR, 8'h0D);
      chk({7'h0, den}, 8'h01, "detect en");
   endtask
   // unmapped write and a write with the enable low must both vanish
   task automatic t_refuse();
      wr(12'h202, 8'hFF);
      rdc(12'h202, 8'h00);
      @(negedge core_clk_i) clk_en_i = 1'b0;
      wr(CMFD_ADDR_MODE, 8'h01);
      clk_en_i = 1'b1;
      rdc(CMFD_ADDR_MODE, 8'hEF);
   endtask
   initial
   begin
      repeat (8) @(negedge core_clk_i);
      reset_n_i = 1'b1;
      t_reset();
      t_mode();
      t_decim();
      t_force();
      t_refuse();
      finish_test();
   end
endmodule
`default_nettype wire
